// >>> operand_address_generator_pkg.sv
// shared constants and types for the operand address generator
package operand_address_generator_pkg;

    // ------------------------------------------------------------------
    // sizes and fixed values
    // ------------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int GP_COUNT = 8;
    localparam int GP_IDX_W = 3;
    localparam logic [2:0] REGISTER_SEVEN = 3'h7;
    localparam logic [7:0] SHORT_ABS_HIGH = 8'hFF;
    localparam logic [7:0] MEM_IND_HIGH = 8'h00;
    localparam logic [15:0] STEP_ONE = 16'h0001;
    localparam logic [15:0] STEP_TWO = 16'h0002;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [2:0] RESET_BIT_NUM = 3'h0;

    // ------------------------------------------------------------------
    // operation classes
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_BYTE_MOVE = 5'h00,
        OP_WORD_MOVE = 5'h01,
        OP_WORD_ADD = 5'h02,
        OP_WORD_SUBTRACT = 5'h03,
        OP_WORD_COMPARE = 5'h04,
        OP_STEP_ADD = 5'h05,
        OP_STEP_SUBTRACT = 5'h06,
        OP_UNSIGNED_MULTIPLY = 5'h07,
        OP_UNSIGNED_DIVIDE = 5'h08,
        OP_BYTE_ALU_IMM = 5'h09,
        OP_BYTE_ALU = 5'h0A,
        OP_BIT = 5'h0B,
        OP_BIT_REGPOS = 5'h0C,
        OP_BRANCH = 5'h0D,
        OP_JUMP = 5'h0E,
        OP_PUSH = 5'h0F,
        OP_POP = 5'h10
    } op_class_t;

    // ------------------------------------------------------------------
    // addressing modes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_REG = 4'h0,
        MODE_IND = 4'h1,
        MODE_DISP = 4'h2,
        MODE_POSTINC = 4'h3,
        MODE_PREDEC = 4'h4,
        MODE_ABS8 = 4'h5,
        MODE_ABS16 = 4'h6,
        MODE_IMM8 = 4'h7,
        MODE_IMM16 = 4'h8,
        MODE_PCREL = 4'h9,
        MODE_MEMIND = 4'hA
    } addr_mode_t;

    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CALC = 3'b010,
        ST_INDIRECT = 3'b100
    } oag_state_t;

endpackage

// >>> gp_register_file.sv
// general register file, two registered read ports, one byte-lane write
`timescale 1ns/100ps
`default_nettype none
module gp_register_file
    import operand_address_generator_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int IDX_W = 3
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // read ports
    input wire logic [IDX_W-1:0] rd_a_idx,
    output logic [WIDTH-1:0] rd_a_data,
    input wire logic [IDX_W-1:0] rd_b_idx,
    output logic [WIDTH-1:0] rd_b_data,
    // write port
    input wire logic wr_en,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic [1:0] wr_be,
    input wire logic [WIDTH-1:0] wr_data
);

    initial begin
        if (WIDTH != 16 || DEPTH > (1 << IDX_W) || DEPTH < 8) begin
            $error("gp_register_file: unsupported geometry");
        end
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];

    // ------------------------------------------------------------------
    // storage, not reset
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (wr_en && wr_be[0]) begin
            mem_reg[wr_idx][7:0] <= wr_data[7:0];
        end
        if (wr_en && wr_be[1]) begin
            mem_reg[wr_idx][15:8] <= wr_data[15:8];
        end
    end

    // ------------------------------------------------------------------
    // registered reads
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rd_a_data <= RESET_WORD;
            rd_b_data <= RESET_WORD;
        end else begin
            rd_a_data <= mem_reg[rd_a_idx];
            rd_b_data <= mem_reg[rd_b_idx];
        end
    end

endmodule
`default_nettype wire

// >>> address_adder.sv
// 16-bit address adder for displacement, step and relative forms
`timescale 1ns/100ps
`default_nettype none
module address_adder
    import operand_address_generator_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // operands
    input wire logic [WIDTH-1:0] base,
    input wire logic [WIDTH-1:0] offset,
    // result
    output logic [WIDTH-1:0] sum
);

    initial begin
        if (WIDTH != ADDR_W) begin
            $error("address_adder: width must match address width");
        end
    end

    // wraps within the 64-kbyte space
    assign sum = base + offset;

endmodule
`default_nettype wire

// >>> operand_address_generator.sv
// operand and branch-target address generation with register write-back
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - register-direct takes the selected register as byte or word operand.
// - only word move/add/sub/compare, step, multiply, divide, push and pop use word operands.
// - register-indirect uses the full 16-bit register as address.
// - displacement adds bytes three-four to register; moves only; word even.
// - post-increment accesses register address, then adds 1 byte, 2 word.
// - pre-decrement subtracts 1 or 2 first, uses and keeps result.
// - short absolute address has upper byte forced to all ones.
// - short absolute for byte move and bit ops; long for moves, jumps.
// - immediate byte from byte two; word from bytes three-four, word move.
// - step add and subtract supply implicit immediate one or two.
// - bit ops carry 3-bit bit number in byte two or four.
// - branches sign-extend byte-two displacement and add program counter.
// - memory-indirect zero-extends byte two, reads target word there.
// - odd branch target or word-move address accesses preceding even word.
// - arithmetic uses register direct; some byte ops also take immediates.
// - data transfers refuse relative and memory indirect; byte move also word immediate, word move short absolute and byte immediate.
// - bit ops use direct, indirect or short absolute; some take register position.
// - push is word store pre-decrement, pop word load post-increment.
// - register seven serves as the implicit stack pointer.
// - instruction fetch address always has its lowest bit cleared.
module operand_address_generator
    import operand_address_generator_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // instruction from fetch path
    input wire logic instr_valid,
    input wire op_class_t instr_op,
    input wire addr_mode_t instr_mode,
    input wire logic [2:0] instr_reg_sel,
    input wire logic instr_reg_high,
    input wire logic [7:0] instr_byte2,
    input wire logic [15:0] instr_ext_word,
    input wire logic [15:0] program_counter,
    input wire logic instr_step_two,
    input wire logic bit_num_in_byte4,
    input wire logic bit_pos_from_reg,
    input wire logic [2:0] bit_reg_sel,
    input wire logic bit_reg_high,
    // core register write
    input wire logic core_wr_en,
    input wire logic [2:0] core_wr_idx,
    input wire logic [1:0] core_wr_be,
    input wire logic [15:0] core_wr_data,
    // data memory bus, pointer read
    output logic mem_req,
    output logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    // results
    output logic busy,
    output logic ea_valid,
    output logic [15:0] ea_addr,
    output logic ea_is_memory,
    output logic [15:0] operand_data,
    output logic operand_word,
    output logic [15:0] step_imm,
    output logic [2:0] bit_number,
    output logic mode_fault,
    output logic [15:0] fetch_addr
);

    oag_state_t state_reg, state_next;
    op_class_t op_reg;
    addr_mode_t mode_reg;
    logic [2:0] sel_reg;
    logic high_reg, step_two_reg, byte4_reg, regpos_reg, bit_high_reg;
    logic [7:0] byte2_reg;
    logic [15:0] ext_reg, pc_reg;
    logic [2:0] rd_a_idx, rd_b_idx, wr_idx;
    logic [15:0] rd_a_data, rd_b_data, wr_data;
    logic [1:0] wr_be;
    logic wr_en;
    logic [15:0] add_a, add_b, add_sum, step_amt, ea_comb, opnd_comb;
    logic [7:0] bitsrc_byte;
    addr_mode_t eff_mode;
    logic is_word, fault_comb, mem_mode, clear_lsb, wb_comb;
    logic [15:0] pcrel_exp;

    // ------------------------------------------------------------------
    // register file and adder
    // ------------------------------------------------------------------
    always_comb begin
        rd_a_idx = instr_reg_sel;
        if (instr_op == OP_PUSH || instr_op == OP_POP) begin
            rd_a_idx = REGISTER_SEVEN;
        end
        rd_b_idx = bit_reg_sel;
    end

    gp_register_file #(
        .WIDTH(ADDR_W),
        .DEPTH(GP_COUNT),
        .IDX_W(GP_IDX_W)
    ) u_regs (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .rd_a_idx(rd_a_idx),
        .rd_a_data(rd_a_data),
        .rd_b_idx(rd_b_idx),
        .rd_b_data(rd_b_data),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_be(wr_be),
        .wr_data(wr_data)
    );

    address_adder #(
        .WIDTH(ADDR_W)
    ) u_adder (
        .base(add_a),
        .offset(add_b),
        .sum(add_sum)
    );

    // ------------------------------------------------------------------
    // decode of the latched instruction
    // ------------------------------------------------------------------
    always_comb begin
        eff_mode = mode_reg;
        if (op_reg == OP_PUSH) begin
            eff_mode = MODE_PREDEC;
        end else if (op_reg == OP_POP) begin
            eff_mode = MODE_POSTINC;
        end
        case (op_reg)
            OP_WORD_MOVE, OP_WORD_ADD, OP_WORD_SUBTRACT, OP_WORD_COMPARE,
            OP_STEP_ADD, OP_STEP_SUBTRACT, OP_UNSIGNED_MULTIPLY,
            OP_UNSIGNED_DIVIDE, OP_PUSH, OP_POP: is_word = 1'b1;
            default: is_word = 1'b0;
        endcase
        step_amt = is_word ? STEP_TWO : STEP_ONE;
    end

    always_comb begin
        fault_comb = 1'b1;
        case (eff_mode)
            MODE_REG: fault_comb = (op_reg == OP_BRANCH) ||
                (op_reg == OP_JUMP);
            MODE_IND: fault_comb = !(op_reg == OP_BYTE_MOVE ||
                op_reg == OP_WORD_MOVE || op_reg == OP_BIT ||
                op_reg == OP_BIT_REGPOS);
            MODE_DISP, MODE_POSTINC, MODE_PREDEC: fault_comb =
                !(op_reg == OP_BYTE_MOVE || op_reg == OP_WORD_MOVE ||
                op_reg == OP_PUSH || op_reg == OP_POP);
            MODE_ABS8: fault_comb = !(op_reg == OP_BYTE_MOVE ||
                op_reg == OP_BIT || op_reg == OP_BIT_REGPOS);
            MODE_ABS16: fault_comb = !(op_reg == OP_BYTE_MOVE ||
                op_reg == OP_WORD_MOVE || op_reg == OP_JUMP);
            MODE_IMM8: fault_comb = !(op_reg == OP_BYTE_MOVE ||
                op_reg == OP_BYTE_ALU_IMM);
            MODE_IMM16: fault_comb = (op_reg != OP_WORD_MOVE);
            MODE_PCREL: fault_comb = (op_reg != OP_BRANCH);
            MODE_MEMIND: fault_comb = (op_reg != OP_JUMP);
            default: fault_comb = 1'b1;
        endcase
    end

    // ------------------------------------------------------------------
    // effective address and operand forming
    // ------------------------------------------------------------------
    always_comb begin
        add_a = rd_a_data;
        add_b = ZERO_WORD;
        case (eff_mode)
            MODE_DISP: add_b = ext_reg;
            MODE_POSTINC: add_b = step_amt;
            MODE_PREDEC: add_b = ZERO_WORD - step_amt;
            MODE_PCREL: begin
                add_a = pc_reg;
                add_b = {{8{byte2_reg[7]}}, byte2_reg};
            end
            default: add_b = ZERO_WORD;
        endcase
    end

    always_comb begin
        ea_comb = ZERO_WORD;
        mem_mode = 1'b1;
        case (eff_mode)
            MODE_IND: ea_comb = rd_a_data;
            MODE_DISP: ea_comb = add_sum;
            MODE_POSTINC: ea_comb = rd_a_data;
            MODE_PREDEC: ea_comb = add_sum;
            MODE_ABS8: ea_comb = {SHORT_ABS_HIGH, byte2_reg};
            MODE_ABS16: ea_comb = ext_reg;
            MODE_PCREL: ea_comb = add_sum;
            MODE_MEMIND: ea_comb = {MEM_IND_HIGH, byte2_reg};
            default: mem_mode = 1'b0;
        endcase
        clear_lsb = (mem_mode && is_word) || eff_mode == MODE_PCREL ||
            eff_mode == MODE_MEMIND || op_reg == OP_JUMP;
        if (clear_lsb) begin
            ea_comb[0] = 1'b0;
        end
    end

    always_comb begin
        opnd_comb = ZERO_WORD;
        case (eff_mode)
            MODE_REG: begin
                if (is_word) begin
                    opnd_comb = rd_a_data;
                end else if (high_reg) begin
                    opnd_comb = {8'h00, rd_a_data[15:8]};
                end else begin
                    opnd_comb = {8'h00, rd_a_data[7:0]};
                end
            end
            MODE_IMM8: opnd_comb = {8'h00, byte2_reg};
            MODE_IMM16: opnd_comb = ext_reg;
            default: opnd_comb = ZERO_WORD;
        endcase
        bitsrc_byte = bit_num_sel_byte(byte4_reg, byte2_reg, ext_reg);
        if (regpos_reg && op_reg == OP_BIT_REGPOS) begin
            bitsrc_byte = bit_high_reg ? rd_b_data[15:8] : rd_b_data[7:0];
        end
    end

    function automatic logic [7:0] bit_num_sel_byte(input logic b4,
        input logic [7:0] b2, input logic [15:0] ext);
        bit_num_sel_byte = b4 ? ext[7:0] : b2;
    endfunction

    assign wb_comb = (state_reg == ST_CALC) && !fault_comb &&
        (eff_mode == MODE_POSTINC || eff_mode == MODE_PREDEC);

    // auto-step write-back wins the single write port over the core
    always_comb begin
        wr_en = core_wr_en;
        wr_idx = core_wr_idx;
        wr_be = core_wr_be;
        wr_data = core_wr_data;
        if (wb_comb) begin
            wr_en = 1'b1;
            wr_idx = (op_reg == OP_PUSH || op_reg == OP_POP) ?
                REGISTER_SEVEN : sel_reg;
            wr_be = 2'b11;
            wr_data = add_sum;
        end
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (instr_valid) state_next = ST_CALC;
            ST_CALC: begin
                if (eff_mode == MODE_MEMIND && !fault_comb) begin
                    state_next = ST_INDIRECT;
                end else begin
                    state_next = ST_IDLE;
                end
            end
            ST_INDIRECT: if (mem_ack) state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            op_reg <= OP_BYTE_MOVE;
            mode_reg <= MODE_REG;
            sel_reg <= 3'h0;
            high_reg <= 1'b0;
            byte2_reg <= 8'h00;
            ext_reg <= RESET_WORD;
            pc_reg <= RESET_WORD;
            step_two_reg <= 1'b0;
            byte4_reg <= 1'b0;
            regpos_reg <= 1'b0;
            bit_high_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && instr_valid) begin
            op_reg <= instr_op;
            mode_reg <= instr_mode;
            sel_reg <= instr_reg_sel;
            high_reg <= instr_reg_high;
            byte2_reg <= instr_byte2;
            ext_reg <= instr_ext_word;
            pc_reg <= program_counter;
            step_two_reg <= instr_step_two;
            byte4_reg <= bit_num_in_byte4;
            regpos_reg <= bit_pos_from_reg;
            bit_high_reg <= bit_reg_high;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_next != ST_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // result registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ea_valid <= 1'b0;
            ea_addr <= RESET_WORD;
            ea_is_memory <= 1'b0;
            operand_data <= RESET_WORD;
            operand_word <= 1'b0;
            step_imm <= RESET_WORD;
            bit_number <= RESET_BIT_NUM;
            mode_fault <= 1'b0;
        end else begin
            ea_valid <= 1'b0;
            if (state_reg == ST_CALC) begin
                ea_addr <= ea_comb;
                ea_is_memory <= mem_mode;
                operand_data <= opnd_comb;
                operand_word <= is_word;
                step_imm <= step_two_reg ? STEP_TWO : STEP_ONE;
                bit_number <= bitsrc_byte[2:0];
                mode_fault <= fault_comb;
                ea_valid <= !(eff_mode == MODE_MEMIND && !fault_comb);
            end else if (state_reg == ST_INDIRECT && mem_ack) begin
                ea_addr <= {mem_rdata[15:1], 1'b0};
                ea_valid <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mem_req <= 1'b0;
            mem_addr <= RESET_WORD;
        end else if (state_reg == ST_CALC && eff_mode == MODE_MEMIND &&
            !fault_comb) begin
            mem_req <= 1'b1;
            mem_addr <= ea_comb;
        end else if (state_reg == ST_INDIRECT && mem_ack) begin
            mem_req <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fetch_addr <= RESET_WORD;
        end else begin
            fetch_addr <= {program_counter[15:1], 1'b0};
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    assign pcrel_exp = pc_reg + {{8{byte2_reg[7]}}, byte2_reg};

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    chk_fetch_even: assert property (
        !fetch_addr[0]) else $error("fetch address odd");
    chk_short_abs: assert property (
        state_reg == ST_CALC && eff_mode == MODE_ABS8
        |=> ea_addr[15:8] == 8'hFF) else $error("short absolute high byte");
    chk_memind_low: assert property (
        state_reg == ST_CALC && eff_mode == MODE_MEMIND && !fault_comb
        |=> mem_req && mem_addr[15:8] == 8'h00 && !ea_valid)
        else $error("memory indirect pointer address");
    chk_word_even: assert property (
        ea_valid && operand_word && ea_is_memory |-> !ea_addr[0])
        else $error("word access at odd address");
    chk_predec_addr: assert property (
        state_reg == ST_CALC && eff_mode == MODE_PREDEC && is_word &&
        !fault_comb && !rd_a_data[0]
        |=> ea_addr == $past(rd_a_data) - 16'h0002 && ea_valid)
        else $error("pre-decrement address");
    chk_postinc_wb: assert property (
        state_reg == ST_CALC && eff_mode == MODE_POSTINC && !is_word &&
        !fault_comb |-> wr_en && wr_data == rd_a_data + 16'h0001)
        else $error("post-increment write-back");
    chk_pcrel_target: assert property (
        state_reg == ST_CALC && eff_mode == MODE_PCREL && !fault_comb
        |=> ea_addr == {$past(pcrel_exp[15:1]), 1'b0})
        else $error("relative branch target");
    chk_byte_operand: assert property (
        state_reg == ST_CALC && eff_mode == MODE_REG &&
        op_reg == OP_BYTE_ALU |=> !operand_word &&
        operand_data[15:8] == 8'h00) else $error("byte operand width");
    chk_xfer_fault: assert property (
        state_reg == ST_CALC && eff_mode == MODE_MEMIND &&
        op_reg == OP_BYTE_MOVE |=> mode_fault && ea_valid)
        else $error("transfer with memory indirect not refused");
    chk_stack_reg: assert property (
        state_reg == ST_IDLE && instr_valid && instr_op == OP_PUSH
        |-> rd_a_idx == 3'h7) else $error("push not on register seven");
    chk_indirect_done: assert property (
        state_reg == ST_INDIRECT && mem_ack |=> ea_valid ##1 !ea_valid)
        else $error("indirect target not presented once");

endmodule
`default_nettype wire

// >>> oag_mem_model.sv
// data memory responder for pointer reads
`timescale 1ns/100ps
`default_nettype none
module oag_mem_model #(
    parameter int LAT = 3
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // pointer read bus
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    output logic mem_ack,
    output logic [15:0] mem_rdata
);
    int wait_cnt;
    // answers 45 over pointer address low byte with bit 0 set, data toggles when not answering
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wait_cnt <= 0;
            mem_ack <= 1'b0;
            mem_rdata <= 16'h5a5a;
        end else if (mem_req && !mem_ack && wait_cnt == LAT) begin
            wait_cnt <= 0;
            mem_ack <= 1'b1;
            mem_rdata <= {8'h45, mem_addr[7:0]} | 16'h0001;
        end else begin
            wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 1 : 0;
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule
`default_nettype wire

// >>> tb_operand_address_generator.sv
// testbench for the operand address generator
`timescale 1ns/100ps
`default_nettype none
module tb_operand_address_generator;
    import operand_address_generator_pkg::*;
    logic clk_sys = 0, rstn = 0, instr_valid = 0, instr_reg_high = 0;
    logic instr_step_two = 0, bit_num_in_byte4 = 0, bit_pos_from_reg = 0;
    logic bit_reg_high = 0, core_wr_en = 0, mem_req, mem_ack;
    op_class_t instr_op = OP_BYTE_MOVE;
    addr_mode_t instr_mode = MODE_REG;
    logic [2:0] instr_reg_sel = 0, bit_reg_sel = 0, core_wr_idx = 0;
    logic [1:0] core_wr_be = 2'h3;
    logic [7:0] instr_byte2 = 0;
    logic [15:0] instr_ext_word = 0, program_counter = 0, core_wr_data = 0;
    logic [15:0] mem_addr, mem_rdata, ea_addr, operand_data, step_imm;
    logic [15:0] fetch_addr;
    logic busy, ea_valid, ea_is_memory, operand_word, mode_fault;
    logic [2:0] bit_number;
    int failures = 0, cmp_count = 0;
    always #2 clk_sys = ~clk_sys;
    operand_address_generator dut_u (.clk_sys(clk_sys), .rstn(rstn),
        .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_mode(instr_mode), .instr_reg_sel(instr_reg_sel),
        .instr_reg_high(instr_reg_high), .instr_byte2(instr_byte2),
        .instr_ext_word(instr_ext_word), .program_counter(program_counter),
        .instr_step_two(instr_step_two), .bit_num_in_byte4(bit_num_in_byte4),
        .bit_pos_from_reg(bit_pos_from_reg), .bit_reg_sel(bit_reg_sel),
        .bit_reg_high(bit_reg_high), .core_wr_en(core_wr_en),
        .core_wr_idx(core_wr_idx), .core_wr_be(core_wr_be),
        .core_wr_data(core_wr_data), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy),
        .ea_valid(ea_valid), .ea_addr(ea_addr), .ea_is_memory(ea_is_memory),
        .operand_data(operand_data), .operand_word(operand_word),
        .step_imm(step_imm), .bit_number(bit_number),
        .mode_fault(mode_fault), .fetch_addr(fetch_addr));
    oag_mem_model mem_u (.clk_sys(clk_sys), .rstn(rstn), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] idx, input logic [15:0] d);
        @(negedge clk_sys);
        core_wr_en = 1; core_wr_idx = idx; core_wr_data = d;
        @(negedge clk_sys);
        core_wr_en = 0;
    endtask
    task automatic req(input op_class_t op, input addr_mode_t md,
        input logic [2:0] rs, input logic [7:0] b2, input logic [15:0] ext);
        int n;
        @(negedge clk_sys);
        instr_valid = 1; instr_op = op; instr_mode = md;
        instr_reg_sel = rs; instr_byte2 = b2; instr_ext_word = ext;
        @(negedge clk_sys);
        instr_valid = 0;
        n = 0;
        while (ea_valid !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 50) check(16'h0, 16'h1);
    endtask
    task automatic finish_test;
        if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_auto;
        wr(3, 16'h1000); wr(2, 16'h2000);
        req(OP_BYTE_MOVE, MODE_POSTINC, 3, 0, 0);
        check(ea_addr, 16'h1000);
        req(OP_BYTE_MOVE, MODE_IND, 3, 0, 0);
        check(ea_addr, 16'h1001);
        req(OP_WORD_MOVE, MODE_PREDEC, 2, 0, 0);
        check(ea_addr, 16'h1ffe);
        req(OP_WORD_MOVE, MODE_IND, 2, 0, 0);
        check(ea_addr, 16'h1ffe);
    endtask
    task automatic t_abs;
        req(OP_BYTE_MOVE, MODE_ABS8, 0, 8'h34, 0);
        check(ea_addr, 16'hff34);
        check({15'h0, ea_is_memory}, 16'h0001);
        check({15'h0, busy}, 16'h0000);
        req(OP_BYTE_MOVE, MODE_MEMIND, 0, 8'h20, 0);
        check({15'h0, mode_fault}, 16'h0001);
        req(OP_JUMP, MODE_ABS16, 0, 0, 16'h4321);
        check(ea_addr, 16'h4320);
        req(OP_WORD_MOVE, MODE_DISP, 2, 0, 16'h0003);
        check(ea_addr, 16'h2000);
    endtask
    task automatic t_branch;
        program_counter = 16'h1001;
        req(OP_BRANCH, MODE_PCREL, 0, 8'hf0, 0);
        check(ea_addr, 16'h0ff0);
        check(fetch_addr, 16'h1000);
        req(OP_JUMP, MODE_MEMIND, 0, 8'h20, 0);
        check(ea_addr, 16'h4520);
    endtask
    task automatic t_operand;
        wr(4, 16'habcd);
        req(OP_WORD_ADD, MODE_REG, 4, 0, 0);
        check(operand_data, 16'habcd);
        check({15'h0, operand_word}, 16'h0001);
        req(OP_BYTE_ALU, MODE_REG, 4, 0, 0);
        check(operand_data, 16'h00cd);
        req(OP_WORD_MOVE, MODE_IMM16, 0, 0, 16'h1234);
        check(operand_data, 16'h1234);
        instr_step_two = 1;
        req(OP_STEP_ADD, MODE_REG, 4, 0, 0);
        check(step_imm, 16'h0002);
        bit_num_in_byte4 = 1;
        req(OP_BIT, MODE_ABS8, 0, 8'h10, 16'h0006);
        check({13'h0, bit_number}, 16'h0006);
        wr(5, 16'h000b);
        bit_reg_sel = 5; bit_pos_from_reg = 1;
        req(OP_BIT_REGPOS, MODE_REG, 0, 0, 0);
        check({13'h0, bit_number}, 16'h0003);
        bit_pos_from_reg = 0;
    endtask
    task automatic t_stack;
        wr(7, 16'h3000);
        req(OP_PUSH, MODE_REG, 1, 0, 0);
        check(ea_addr, 16'h2ffe);
        req(OP_POP, MODE_REG, 1, 0, 0);
        check(ea_addr, 16'h2ffe);
        req(OP_WORD_MOVE, MODE_IND, 7, 0, 0);
        check(ea_addr, 16'h3000);
    endtask
    initial begin
        #20000;
        failures++;
        finish_test;
    end
    initial begin
        repeat (5) @(negedge clk_sys);
        rstn = 1;
        t_auto; t_abs; t_branch; t_operand; t_stack;
        finish_test;
    end
endmodule
`default_nettype wire
